// File: smr_cfg.svh
// Register offsets, field positions and reset values of the supply monitor control block.
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// Register byte offsets on the APB bus.
`define SMR_OFS_CONFIG 8'h00
`define SMR_OFS_STATUS 8'h04
`define SMR_OFS_EVENT 8'h08
`define SMR_OFS_EVCLEAR 8'h0c
`define SMR_OFS_EVENABLE 8'h10
`define SMR_OFS_CAUSE 8'h14

// Configuration register field positions.
`define SMR_CFG_POWER_OFF 0
`define SMR_CFG_RESET_INHIBIT 1
`define SMR_CFG_STOP_ENABLE 2
`define SMR_CFG_TRIP_RANGE 3
`define SMR_CFG_LOCKED 8

// Status register field positions.
`define SMR_ST_BELOW 0
`define SMR_ST_ACTIVE 1
`define SMR_ST_IN_RESET 2

// Event bit positions, shared by event, clear and enable registers.
`define SMR_EV_FELL 0
`define SMR_EV_ROSE 1
`define SMR_EV_RESET 2
`define SMR_EV_W 3

// Reset-cause register field positions.
`define SMR_CAUSE_POR 0
`define SMR_CAUSE_MONITOR 1

// Reset values.
`define SMR_CFG_RESET 4'h0
`define SMR_EVEN_RESET 3'h0

`endif

// File: smr_pkg.sv
// Types shared by the supply monitor control block.
package smr_pkg;

  // Write-once configuration bits as held by the block.
  typedef struct packed {
    logic tripRangeSelect;
    logic monitorInStopEnable;
    logic monitorResetInhibit;
    logic monitorPowerOff;
  } smr_cfg_t;

  // Monitor reset sequencing states.
  typedef enum logic {
    SMR_WATCH,
    SMR_HOLD
  } smr_state_t;

  // Decoded register selection.
  typedef enum logic [2:0] {
    SMR_SEL_CONFIG,
    SMR_SEL_STATUS,
    SMR_SEL_EVENT,
    SMR_SEL_EVCLEAR,
    SMR_SEL_EVENABLE,
    SMR_SEL_CAUSE,
    SMR_SEL_NONE
  } smr_sel_t;

endpackage

// File: smr_supply_monitor.sv
// Supply monitor control block: configuration, comparator sync, reset hold and APB registers.
`timescale 1ns/100ps
`default_nettype none
`include "smr_cfg.svh"

// What this block does
// - Monitor is active after reset with no software action needed.
// - Trip-range select resets to zero, the lower supply range.
// - Power-off bit disables the monitor: no resets, flag held low.
// - Reset-inhibit bit stops the monitor from ever asserting system reset.
// - In stop mode the monitor runs only when stop enable is set.
// - Trip-range select one picks the higher-range falling threshold.
// - Status below-threshold flag follows the comparator for software polling.
// - Both disable bits clear means reset whenever supply falls below threshold.
// - A monitor reset holds until the supply rises above the rising threshold or resets are no longer allowed.
// - Configuration is write-once; later writes change nothing.
// - Selecting the higher range while supply is below the lower range's rising threshold resets at once.
// - Each monitor reset sets its own bit in the reset-cause register.
module smr_supply_monitor
  import smr_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmpBelowFall,
  input wire logic cmpAboveRise,
  input wire logic stopMode,
  output logic monitorPowered,
  output logic tripHighSel,
  output logic monitorResetReq,
  output logic irq
);

  // ************************************************************
  // Parameter check
  // ************************************************************

  // The register map needs at least byte offsets up to 0x14.
  if (ADDR_W < 5)
  begin : gen_addr_check
    $error("ADDR_W too small for the register map.");
  end

  // Decodes a byte address into a register selection.
  function automatic smr_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (addr != ADDR_W'(a))
      return SMR_SEL_NONE;
    unique case (a)
      `SMR_OFS_CONFIG: return SMR_SEL_CONFIG;
      `SMR_OFS_STATUS: return SMR_SEL_STATUS;
      `SMR_OFS_EVENT: return SMR_SEL_EVENT;
      `SMR_OFS_EVCLEAR: return SMR_SEL_EVCLEAR;
      `SMR_OFS_EVENABLE: return SMR_SEL_EVENABLE;
      `SMR_OFS_CAUSE: return SMR_SEL_CAUSE;
      default: return SMR_SEL_NONE;
    endcase
  endfunction

  logic [1:0] cmpMeta;
  logic [1:0] cmpSync;
  smr_cfg_t cfg;
  logic cfgLocked;
  smr_state_t state;
  smr_state_t next_state;
  logic prevBelow;
  logic [`SMR_EV_W-1:0] evStatus;
  logic [`SMR_EV_W-1:0] evEnable;
  logic [1:0] rstCause;
  smr_sel_t sel;
  logic apbDone;
  logic apbWrite;
  logic apbRead;
  logic cfgWrite;
  logic monActive;
  logic rstAllowed;
  logic belowFlag;
  logic highRangeTrip;
  logic [`SMR_EV_W-1:0] evSet;

  // ************************************************************
  // Comparator synchronisers
  // ************************************************************

  // two-stage sync: bit 0 is below-falling, bit 1 is above-rising.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmpMeta <= 2'h0;
      cmpSync <= 2'h0;
    end
    else
    begin
      cmpMeta <= {cmpAboveRise, cmpBelowFall};
      cmpSync <= cmpMeta;
    end
  end

  // ************************************************************
  // APB access decode
  // ************************************************************

  // A transfer completes in the access cycle in which pready is high.
  assign sel = decodeSel(paddr);
  assign apbDone = psel && penable && pready;
  assign apbWrite = apbDone && pwrite;
  assign apbRead = apbDone && !pwrite;
  assign cfgWrite = apbWrite && (sel == SMR_SEL_CONFIG) && !cfgLocked;

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // ************************************************************
  // Write-once configuration
  // ************************************************************

  // write once: the first write locks every configuration bit.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // low range default: all bits start cleared.
      cfg <= smr_cfg_t'(`SMR_CFG_RESET);
      cfgLocked <= 1'b0;
    end
    else if (cfgWrite)
    begin
      cfg.monitorPowerOff <= pwdata[`SMR_CFG_POWER_OFF];
      cfg.monitorResetInhibit <= pwdata[`SMR_CFG_RESET_INHIBIT];
      cfg.monitorInStopEnable <= pwdata[`SMR_CFG_STOP_ENABLE];
      cfg.tripRangeSelect <= pwdata[`SMR_CFG_TRIP_RANGE];
      cfgLocked <= 1'b1;
    end
  end

  // ************************************************************
  // Monitor activity and flag
  // ************************************************************

  // power off and stop gating decide whether the monitor runs.
  assign monActive = !cfg.monitorPowerOff && (!stopMode || cfg.monitorInStopEnable);
  // inhibit: resets are only allowed while not inhibited.
  assign rstAllowed = monActive && !cfg.monitorResetInhibit;
  // flag follows the synchronised comparator while the monitor runs.
  assign belowFlag = cmpSync[0] && monActive;

  // higher range chosen while supply is under the low range's rising threshold.
  assign highRangeTrip = cfgWrite && pwdata[`SMR_CFG_TRIP_RANGE] && !pwdata[`SMR_CFG_POWER_OFF]
                         && !pwdata[`SMR_CFG_RESET_INHIBIT] && !cmpSync[1];

  // Drives the analog enable and range select from flip-flops.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      monitorPowered <= 1'b1;
      tripHighSel <= 1'b0;
    end
    else
    begin
      monitorPowered <= monActive;
      // range select steers the analog threshold.
      tripHighSel <= cfg.tripRangeSelect;
    end
  end

  // ************************************************************
  // Reset sequencing
  // ************************************************************

  // Chooses between watching the supply and holding the system in reset.
  always_comb
  begin
    next_state = state;
    unique case (state)
      SMR_WATCH:
      begin
        // forced reset on a fall below the falling threshold.
        if ((rstAllowed && cmpSync[0]) || highRangeTrip)
          next_state = SMR_HOLD;
      end
      SMR_HOLD:
      begin
        // hold until the supply is back above the rising threshold or resets stop being allowed.
        if (!rstAllowed || cmpSync[1])
          next_state = SMR_WATCH;
      end
    endcase
  end

  // Registers the state and the reset request that follows it.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= SMR_WATCH;
      monitorResetReq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      monitorResetReq <= (next_state == SMR_HOLD);
    end
  end

  // ************************************************************
  // Events, interrupt and reset cause
  // ************************************************************

  // Edges of the flag and entry into reset are the block's events.
  assign evSet[`SMR_EV_FELL] = belowFlag && !prevBelow;
  assign evSet[`SMR_EV_ROSE] = !belowFlag && prevBelow;
  assign evSet[`SMR_EV_RESET] = (state == SMR_WATCH) && (next_state == SMR_HOLD);

  // Sticky event bits; a set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prevBelow <= 1'b0;
      evStatus <= '0;
    end
    else
    begin
      prevBelow <= belowFlag;
      if (apbWrite && (sel == SMR_SEL_EVCLEAR))
        evStatus <= (evStatus & ~pwdata[`SMR_EV_W-1:0]) | evSet;
      else
        evStatus <= evStatus | evSet;
    end
  end

  // Event enable register and the level interrupt it gates.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      evEnable <= `SMR_EVEN_RESET;
      irq <= 1'b0;
    end
    else
    begin
      if (apbWrite && (sel == SMR_SEL_EVENABLE))
        evEnable <= pwdata[`SMR_EV_W-1:0];
      irq <= |(evStatus & evEnable);
    end
  end

  // reset cause: the monitor owns its own bit, cleared by writing one.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rstCause <= 2'h1;
    else if (apbWrite && (sel == SMR_SEL_CAUSE))
      rstCause <= (rstCause & ~pwdata[1:0]) | {evSet[`SMR_EV_RESET], 1'b0};
    else
      rstCause <= rstCause | {evSet[`SMR_EV_RESET], 1'b0};
  end

  // ************************************************************
  // APB read data
  // ************************************************************

  // Read data and error answer are registered alongside pready.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= 32'h0;
      pslverr <= psel && penable && !pready && (sel == SMR_SEL_NONE);
      if (psel && penable && !pready && !pwrite)
      begin
        unique case (sel)
          SMR_SEL_CONFIG: prdata <= {23'h0, cfgLocked, 4'h0, cfg};
          SMR_SEL_STATUS: prdata <= {29'h0, state == SMR_HOLD, monActive, belowFlag};
          SMR_SEL_EVENT: prdata <= {29'h0, evStatus};
          SMR_SEL_EVENABLE: prdata <= {29'h0, evEnable};
          SMR_SEL_CAUSE: prdata <= {30'h0, rstCause};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************

  sequence seqHoldStays;
    (state == SMR_HOLD) && rstAllowed && !cmpSync[1];
  endsequence

  sequence seqFallSeen;
    (state == SMR_WATCH) && rstAllowed && cmpSync[0];
  endsequence

  sequence seqStatusRead;
    psel && penable && !pready && !pwrite && (sel == SMR_SEL_STATUS);
  endsequence

  start_active_a: assert property (@(posedge clk_sys) $rose(rst_n) |-> monitorPowered && !monitorResetReq)
    else $error("Monitor not active after reset.");

  range_default_a: assert property (@(posedge clk_sys) $rose(rst_n) |-> !cfg.tripRangeSelect && !tripHighSel)
    else $error("Trip range not low after reset.");

  power_off_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.monitorPowerOff |-> !belowFlag ##1 (!monitorResetReq && !monitorPowered))
    else $error("Powered-off monitor still acting.");

  inhibit_no_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.monitorResetInhibit |=> !monitorResetReq)
    else $error("Reset asserted while inhibited.");

  stop_gating_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stopMode && !cfg.monitorInStopEnable |=> !monitorPowered)
    else $error("Monitor running in stop without enable.");

  range_output_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(cfg.tripRangeSelect) |-> ##1 tripHighSel)
    else $error("Range select not driven to the comparator.");

  flag_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqStatusRead |=> prdata[`SMR_ST_BELOW] == $past(belowFlag))
    else $error("Status flag does not follow the comparator.");

  forced_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqFallSeen |=> monitorResetReq && rstCause[`SMR_CAUSE_MONITOR])
    else $error("Fall below threshold did not reset.");

  hold_until_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqHoldStays |=> monitorResetReq && (state == SMR_HOLD))
    else $error("Reset released before supply rose.");

  config_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfgLocked |=> $stable(cfg) && cfgLocked)
    else $error("Locked configuration changed.");

  high_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    highRangeTrip |=> monitorResetReq)
    else $error("Higher range below rising threshold did not reset.");

  cause_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(monitorResetReq) |-> rstCause[`SMR_CAUSE_MONITOR] && evStatus[`SMR_EV_RESET])
    else $error("Monitor reset left no cause bit.");

  sync_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n, 2) |-> cmpSync == $past({cmpAboveRise, cmpBelowFall}, 2))
    else $error("Comparator sync latency is not two cycles.");

endmodule // smr_supply_monitor
`default_nettype wire

// File: smr_cmp_model.sv
// Behavioural comparator pair standing in for the analog side of the supply monitor.
`timescale 1ns/100ps
`default_nettype none
module smr_cmp_model
  import smr_pkg::*;
#(
  parameter int FALL_LO = 2400,
  parameter int RISE_LO = 2500,
  parameter int FALL_HI = 3900,
  parameter int RISE_HI = 4000
)
(
  input wire logic clk_sys,
  input wire logic [15:0] supplyMv,
  input wire logic tripHighSel,
  input wire logic monitorPowered,
  output logic cmpBelowFall,
  output logic cmpAboveRise
);
  logic junk = 1'b0;

  // An unpowered comparator means nothing, so its outputs flip every cycle.
  always @(posedge clk_sys)
    junk <= ~junk;

  assign cmpBelowFall = monitorPowered ? (int'(supplyMv) < (tripHighSel ? FALL_HI : FALL_LO)) : junk;
  assign cmpAboveRise = monitorPowered ? (int'(supplyMv) > (tripHighSel ? RISE_HI : RISE_LO)) : ~junk;
endmodule // smr_cmp_model
`default_nettype wire

// File: smr_supply_monitor_bench.sv
// Self-checking bench for the supply monitor control block.
`timescale 1ns/100ps
`default_nettype none
`include "smr_cfg.svh"
module smr_supply_monitor_bench
  import smr_pkg::*;
;
  // ************************************************************
  // Stimulus, models and checks.
  // ************************************************************
  localparam int FALL_LO = 2400;
  localparam int FALL_HI = 3900;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stopMode = 1'b0;
  logic [15:0] supplyMv = 16'd3000;
  logic [31:0] prdata;
  logic pready, pslverr, cmpBelowFall, cmpAboveRise, monitorPowered, tripHighSel, monitorResetReq, irq;
  logic [31:0] rdv;
  logic errv;
  logic [15:0] s;
  int n_fail = 0;
  int comparisons = 0;
  int k;

  smr_supply_monitor #(.ADDR_W(8)) i_smr_supply_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmpBelowFall(cmpBelowFall), .cmpAboveRise(cmpAboveRise), .stopMode(stopMode),
    .monitorPowered(monitorPowered), .tripHighSel(tripHighSel), .monitorResetReq(monitorResetReq), .irq(irq));

  smr_cmp_model #(.FALL_LO(FALL_LO), .FALL_HI(FALL_HI)) i_smr_cmp_model (.clk_sys(clk_sys),
    .supplyMv(supplyMv), .tripHighSel(tripHighSel), .monitorPowered(monitorPowered),
    .cmpBelowFall(cmpBelowFall), .cmpAboveRise(cmpAboveRise));

  // The 250 MHz system clock.
  initial
    forever #2 clk_sys = ~clk_sys;

  function automatic logic [31:0] z(input logic x);
    return {31'h0, x};
  endfunction

  // Status word expected from a supply level with the monitor active and not holding reset.
  function automatic logic [31:0] exp_status(input logic [15:0] v, input logic hi);
    return {30'h0, 1'b1, int'(v) < (hi ? FALL_HI : FALL_LO)};
  endfunction

  task automatic final_report();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      n_fail++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
    check(z(errv), 32'h0);
  endtask

  // Waits a bounded time for the reset request to reach the given level.
  task automatic wait_req(input logic exp);
    int n;
    n = 0;
    while (monitorResetReq !== exp && n < 8)
    begin
      @(posedge clk_sys);
      n++;
    end
    check(z(monitorResetReq), z(exp));
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    stopMode <= 1'b0;
    supplyMv <= 16'd3000;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  // Main sequence: one scenario per configuration, with a reset between them.
  initial
  begin
    k = $urandom(85634);
    do_reset();
    check(z(monitorPowered), 32'h1);
    check(z(tripHighSel), 32'h0);
    rd(`SMR_OFS_CAUSE, 32'h1);
    rd(`SMR_OFS_CONFIG, 32'h0);
    rd(`SMR_OFS_EVENABLE, 32'h0);
    rd(`SMR_OFS_STATUS, 32'h2);
    repeat (4)
    begin
      apb(1'b0, 8'h18 + 8'(($urandom % 58) * 4), 32'h0);
      check(z(errv), 32'h1);
      check(rdv, 32'h0);
    end
    apb(1'b1, `SMR_OFS_EVENABLE, 32'h4);
    supplyMv <= 16'd2000;
    wait_req(1'b1);
    repeat (2) @(posedge clk_sys);
    check(z(irq), 32'h1);
    rd(`SMR_OFS_STATUS, 32'h7);
    supplyMv <= 16'd2450;
    repeat (8) @(posedge clk_sys);
    check(z(monitorResetReq), 32'h1);
    rd(`SMR_OFS_CAUSE, 32'h3);
    supplyMv <= 16'd3000;
    wait_req(1'b0);
    rd(`SMR_OFS_EVENT, 32'h7);
    apb(1'b1, `SMR_OFS_EVENABLE, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(z(irq), 32'h0);
    apb(1'b1, `SMR_OFS_EVENABLE, 32'h4);
    repeat (2) @(posedge clk_sys);
    check(z(irq), 32'h1);
    apb(1'b1, `SMR_OFS_EVCLEAR, 32'h7);
    repeat (2) @(posedge clk_sys);
    check(z(irq), 32'h0);
    rd(`SMR_OFS_EVENT, 32'h0);
    rd(`SMR_OFS_EVCLEAR, 32'h0);
    apb(1'b1, `SMR_OFS_CAUSE, 32'h2);
    rd(`SMR_OFS_CAUSE, 32'h1);
    do_reset();
    apb(1'b1, `SMR_OFS_CONFIG, 32'h2);
    rd(`SMR_OFS_CONFIG, 32'h102);
    for (k = 0; k < 24; k++)
    begin
      s = 16'd2000 + 16'($urandom % 1000);
      supplyMv <= s;
      repeat (3) @(posedge clk_sys);
      rd(`SMR_OFS_STATUS, exp_status(s, 1'b0));
      check(z(monitorResetReq), 32'h0);
    end
    apb(1'b1, `SMR_OFS_CONFIG, 32'h8);
    rd(`SMR_OFS_CONFIG, 32'h102);
    check(z(tripHighSel), 32'h0);
    do_reset();
    apb(1'b1, `SMR_OFS_CONFIG, 32'h1);
    supplyMv <= 16'd2000;
    repeat (8) @(posedge clk_sys);
    check(z(monitorPowered), 32'h0);
    check(z(monitorResetReq), 32'h0);
    rd(`SMR_OFS_STATUS, 32'h0);
    do_reset();
    stopMode <= 1'b1;
    supplyMv <= 16'd2000;
    repeat (8) @(posedge clk_sys);
    check(z(monitorResetReq), 32'h0);
    rd(`SMR_OFS_STATUS, 32'h0);
    stopMode <= 1'b0;
    wait_req(1'b1);
    do_reset();
    apb(1'b1, `SMR_OFS_CONFIG, 32'h4);
    stopMode <= 1'b1;
    supplyMv <= 16'd2000;
    wait_req(1'b1);
    do_reset();
    supplyMv <= 16'd2450;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, `SMR_OFS_CONFIG, 32'h8);
    @(posedge clk_sys);
    check(z(tripHighSel), 32'h1);
    wait_req(1'b1);
    apb(1'b1, `SMR_OFS_CONFIG, 32'h0);
    rd(`SMR_OFS_CONFIG, 32'h108);
    supplyMv <= 16'd4500;
    wait_req(1'b0);
    final_report();
  end
endmodule // smr_supply_monitor_bench
`default_nettype wire
